// *** logic/tcs_pkg.sv ***
// Constants, field layouts and carrier types of the tuner configuration and status bank
package tcs_pkg;

   // Register addresses on the byte-wide access port
   localparam logic [7:0] TCS_ADDR_GAIN_BIAS   = 8'h00;
   localparam logic [7:0] TCS_ADDR_XTAL_POWER  = 8'h01;
   localparam logic [7:0] TCS_ADDR_REF_DIV     = 8'h02;
   localparam logic [7:0] TCS_ADDR_LOOP_HIGH   = 8'h03;
   localparam logic [7:0] TCS_ADDR_LOOP_LOW    = 8'h04;
   localparam logic [7:0] TCS_ADDR_STATUS      = 8'h05;

   // Power-on values
   localparam logic [7:0] TCS_RST_GAIN_BIAS    = 8'h56;
   localparam logic [7:0] TCS_RST_XTAL_POWER   = 8'h08;
   localparam logic [7:0] TCS_RST_REF_DIV      = 8'h38;
   localparam logic [7:0] TCS_RST_LOOP_HIGH    = 8'h53;
   localparam logic [7:0] TCS_RST_LOOP_LOW     = 8'hf8;

   // Gain / bias control fields
   localparam int unsigned TCS_GB_MOD_BIT      = 7;
   localparam int unsigned TCS_GB_BIAS_HI      = 6;
   localparam int unsigned TCS_GB_BIAS_LO      = 5;
   localparam int unsigned TCS_GB_SIDE_BIT     = 4;
   localparam int unsigned TCS_GB_AGC_HI       = 3;
   localparam int unsigned TCS_GB_AGC_LO       = 1;
   localparam int unsigned TCS_GB_DET_BIT      = 0;

   // Crystal divide / power fields
   localparam int unsigned TCS_XP_DIV_HI       = 7;
   localparam int unsigned TCS_XP_DIV_LO       = 3;
   localparam int unsigned TCS_XP_POWER_DOWN_REQUEST_BIT     = 2;
   localparam int unsigned TCS_XP_STANDBY_REQUEST_BIT     = 1;
   localparam int unsigned TCS_XP_QUADRATURE_OUTPUT_DISABLE_BIT     = 0;

   // Loop divider low byte and status fields
   localparam int unsigned TCS_LL_N_HI         = 7;
   localparam int unsigned TCS_LL_N_LO         = 3;
   localparam logic [7:0]  TCS_LL_USED_MASK    = 8'hf8;
   localparam int unsigned TCS_ST_PUMP_HI      = 4;
   localparam int unsigned TCS_ST_PUMP_LO      = 3;
   localparam int unsigned TCS_ST_PWR_BIT      = 2;
   localparam int unsigned TCS_ST_OK_BIT       = 1;
   localparam int unsigned TCS_ST_IDLE_BIT     = 0;

   // Analog meaning of codes
   localparam logic [2:0]  TCS_AGC_UNDEF_CODE  = 3'h6;
   localparam logic [2:0]  TCS_AGC_TOP_CODE    = 3'h7;
   localparam logic signed [7:0] TCS_AGC_BASE_DBM = -8'sd62;
   localparam logic signed [7:0] TCS_AGC_STEP_DB  = 8'sd2;
   localparam logic signed [7:0] TCS_AGC_TOP_DBM  = -8'sd48;
   localparam logic [3:0]  TCS_GAIN_STEP_DB    = 4'h7;

   // Host programming ranges
   localparam logic [7:0]  TCS_REF_DIV_MIN     = 8'd22;
   localparam logic [7:0]  TCS_REF_DIV_MAX     = 8'd182;
   localparam logic [12:0] TCS_LOOP_DIV_MIN    = 13'd829;
   localparam logic [12:0] TCS_LOOP_DIV_MAX    = 13'd5374;

   // Autoselect machine
   typedef enum logic [1:0]
   {
      TCS_AS_IDLE = 2'b00,
      TCS_AS_RUN  = 2'b01
   } tcs_as_state_type;

   // One access from the serial slave front end
   typedef struct packed
   {
      logic       ptr_load;
      logic [7:0] ptr_addr;
      logic       wr_en;
      logic [7:0] wr_data;
      logic       rd_en;
      logic       stop_read;
   } tcs_bus_req_type;

   // Decoded settings toward the analog and synthesizer blocks
   typedef struct packed
   {
      logic        qpsk_mode;
      logic [3:0]  bb_gain_step_db;
      logic [1:0]  baseband_bias_level;
      logic        high_side_inject;
      logic [2:0]  agc_attack_point;
      logic signed [7:0] agc_attack_dbm;
      logic        agc_code_undefined;
      logic        detector_on;
      logic [4:0]  reference_output_divider;
      logic        chip_active;
      logic        path_active;
      logic        synth_active;
      logic        q_output_on;
      logic [7:0]  ref_divide;
      logic [12:0] loop_divide;
      logic        ref_divide_in_range;
      logic        loop_divide_in_range;
   } tcs_cfg_type;

endpackage : tcs_pkg

// *** logic/tcs_refdiv.sv ***
// Reference output divider: one-cycle tick every code clocks, off for code zero
`timescale 1ns/1ps
`default_nettype none
module tcs_refdiv
   import tcs_pkg::*;
#(
   parameter int unsigned DIV_W = 5
)
(
   input  wire logic             mclk_i,
   input  wire logic             rst_b_i,
   input  wire logic             run_i,
   input  wire logic [DIV_W-1:0] div_code_i,
   output logic                  tick_o,
   output logic                  buf_on_o
);

   logic [DIV_W-1:0] count_r;
   logic             tick_r;
   logic             on_r;
   logic             on_nxt;

   assign on_nxt = run_i && (div_code_i != '0);

   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         count_r <= '0;
         tick_r  <= 1'b0;
         on_r    <= 1'b0;
      end
      else
      begin
         on_r <= on_nxt;
         // Restart once the count reaches or passes code minus one, so a shorter ratio never waits a full wrap
         if (!on_nxt || (count_r >= div_code_i - 1'b1))
         begin
            count_r <= '0;
            tick_r  <= on_nxt;
         end
         else
         begin
            count_r <= count_r + 1'b1;
            tick_r  <= 1'b0;
         end
      end
   end

   assign tick_o   = tick_r;
   assign buf_on_o = on_r;

endmodule : tcs_refdiv
`default_nettype wire

// *** logic/tcs_regs.sv ***
// Tuner configuration and status register bank behind the serial slave front end
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Bit 7: QAM no gain, QPSK +7dB
// - Bits 6:5 pick baseband bias linearity
// - Bit 4: low-side or high-side injection
// - Bits 3:1 set AGC attack point
// - Bit 0 switches power detector
// - Reference output divider; zero turns off
// - Power-down stops all but bus, keeps registers
// - Standby stops path and synthesizer only
// - Divide bit 0 disables Q output
// - Reference divider byte, default 56
// - Loop divider split over high, low bytes
// - Loop divider defaults to 2687
// - Status bits 4:3 mirror pump current
// - Power-cycled flag cleared by read STOP
// - Autoselect success flag at status bit 1
// - Autoselect idle flag at status bit 0
// - Further write bytes go to next register
// - Autoselect runs only when enabled
module tcs_regs
   import tcs_pkg::*;
(
   input  wire logic            mclk_i,
   input  wire logic            rst_b_i,
   input  wire tcs_bus_req_type bus_req_i,
   output logic [7:0]           rd_data_o,
   output logic                 rd_valid_o,
   input  wire logic [1:0]      pump_current_i,
   input  wire logic            autoselect_enable_i,
   input  wire logic            autoselect_done_i,
   input  wire logic            autoselect_ok_i,
   output tcs_cfg_type          cfg_o,
   output logic                 reference_clock_output_o,
   output logic                 ref_buffer_on_o
);

   logic [7:0]       gain_bias_control_r;
   logic [7:0]       crystal_divide_power_r;
   logic [7:0]       reference_divider_r;
   logic [7:0]       loop_divider_high_r;
   logic [7:0]       loop_divider_low_r;
   logic [7:0]       ptr_r;
   logic [7:0]       ptr_nxt;
   logic [7:0]       rd_data_r;
   logic             rd_valid_r;
   logic [7:0]       read_mux;
   logic [7:0]       status_first;
   logic             power_cycled_flag_r;
   logic             autoselect_success_r;
   logic             autoselect_idle;
   tcs_as_state_type as_state_r;
   tcs_as_state_type as_state_nxt;
   logic             as_start;
   logic             wr_hit;
   logic [7:0]       wr_addr;
   logic             power_down_request;
   logic             standby_request;
   logic [12:0]      loop_divide;
   tcs_cfg_type      cfg_r;
   tcs_cfg_type      cfg_nxt;

   // Access pointer: a load names the first register, each byte moves it on
   assign wr_addr = bus_req_i.ptr_load ? bus_req_i.ptr_addr : ptr_r;
   assign wr_hit  = bus_req_i.wr_en;

   always_comb
   begin
      ptr_nxt = ptr_r;
      if (bus_req_i.ptr_load)
      begin
         ptr_nxt = bus_req_i.ptr_addr;
      end
      if (bus_req_i.wr_en || bus_req_i.rd_en)
      begin
         ptr_nxt = wr_addr + 8'h01;
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         ptr_r <= 8'h00;
      end
      else
      begin
         ptr_r <= ptr_nxt;
      end
   end

   // Writable registers; power-down leaves them untouched
   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         gain_bias_control_r    <= TCS_RST_GAIN_BIAS;
         crystal_divide_power_r <= TCS_RST_XTAL_POWER;
         reference_divider_r    <= TCS_RST_REF_DIV;
         loop_divider_high_r    <= TCS_RST_LOOP_HIGH;
         loop_divider_low_r     <= TCS_RST_LOOP_LOW;
      end
      else if (wr_hit)
      begin
         case (wr_addr)
            TCS_ADDR_GAIN_BIAS:
            begin
               gain_bias_control_r <= bus_req_i.wr_data;
            end
            TCS_ADDR_XTAL_POWER:
            begin
               crystal_divide_power_r <= bus_req_i.wr_data;
            end
            TCS_ADDR_REF_DIV:
            begin
               reference_divider_r <= bus_req_i.wr_data;
            end
            TCS_ADDR_LOOP_HIGH:
            begin
               loop_divider_high_r <= bus_req_i.wr_data;
            end
            TCS_ADDR_LOOP_LOW:
            begin
               loop_divider_low_r <= bus_req_i.wr_data & TCS_LL_USED_MASK;
            end
            default:
            begin
               // Status and unmapped addresses take no write
            end
         endcase
      end
   end

   assign power_down_request = crystal_divide_power_r[TCS_XP_POWER_DOWN_REQUEST_BIT];
   assign standby_request    = crystal_divide_power_r[TCS_XP_STANDBY_REQUEST_BIT];
   assign loop_divide        = {loop_divider_high_r, loop_divider_low_r[TCS_LL_N_HI:TCS_LL_N_LO]};

   // Autoselect machine; a new loop divider low byte starts a search
   assign as_start = wr_hit && (wr_addr == TCS_ADDR_LOOP_LOW);

   always_comb
   begin
      as_state_nxt = as_state_r;
      case (as_state_r)
         TCS_AS_IDLE:
         begin
            if (as_start && autoselect_enable_i && !power_down_request && !standby_request)
            begin
               as_state_nxt = TCS_AS_RUN;
            end
         end
         TCS_AS_RUN:
         begin
            // Dropping the enable or the synthesizer aborts the search
            if (!autoselect_enable_i || power_down_request || standby_request || autoselect_done_i)
            begin
               as_state_nxt = TCS_AS_IDLE;
            end
         end
         default:
         begin
            as_state_nxt = TCS_AS_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         as_state_r <= TCS_AS_IDLE;
      end
      else
      begin
         as_state_r <= as_state_nxt;
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         autoselect_success_r <= 1'b0;
      end
      else if (!autoselect_enable_i)
      begin
         autoselect_success_r <= 1'b0;
      end
      else if (as_state_r == TCS_AS_IDLE && as_state_nxt == TCS_AS_RUN)
      begin
         autoselect_success_r <= 1'b0;
      end
      else if (as_state_r == TCS_AS_RUN && autoselect_done_i)
      begin
         autoselect_success_r <= autoselect_ok_i;
      end
   end

   assign autoselect_idle = (as_state_r != TCS_AS_RUN);

   // Power-cycled flag: set only by reset, so no set can collide with the clear
   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         power_cycled_flag_r <= 1'b1;
      end
      else if (bus_req_i.stop_read)
      begin
         power_cycled_flag_r <= 1'b0;
      end
   end

   always_comb
   begin
      status_first                                 = 8'h00;
      status_first[TCS_ST_PUMP_HI:TCS_ST_PUMP_LO]  = pump_current_i;
      status_first[TCS_ST_PWR_BIT]                 = power_cycled_flag_r;
      status_first[TCS_ST_OK_BIT]                  = autoselect_success_r;
      status_first[TCS_ST_IDLE_BIT]                = autoselect_idle;
   end

   // Read path; unmapped addresses answer zero
   always_comb
   begin
      case (wr_addr)
         TCS_ADDR_GAIN_BIAS:  read_mux = gain_bias_control_r;
         TCS_ADDR_XTAL_POWER: read_mux = crystal_divide_power_r;
         TCS_ADDR_REF_DIV:    read_mux = reference_divider_r;
         TCS_ADDR_LOOP_HIGH:  read_mux = loop_divider_high_r;
         TCS_ADDR_LOOP_LOW:   read_mux = loop_divider_low_r & TCS_LL_USED_MASK;
         TCS_ADDR_STATUS:     read_mux = status_first;
         default:             read_mux = 8'h00;
      endcase
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         rd_data_r  <= 8'h00;
         rd_valid_r <= 1'b0;
      end
      else
      begin
         rd_valid_r <= bus_req_i.rd_en;
         if (bus_req_i.rd_en)
         begin
            rd_data_r <= read_mux;
         end
      end
   end

   // Decode of settings toward the analog side
   always_comb
   begin
      cfg_nxt                     = '0;
      cfg_nxt.qpsk_mode           = gain_bias_control_r[TCS_GB_MOD_BIT];
      cfg_nxt.bb_gain_step_db     = gain_bias_control_r[TCS_GB_MOD_BIT] ? TCS_GAIN_STEP_DB : 4'h0;
      cfg_nxt.baseband_bias_level = gain_bias_control_r[TCS_GB_BIAS_HI:TCS_GB_BIAS_LO];
      cfg_nxt.high_side_inject    = gain_bias_control_r[TCS_GB_SIDE_BIT];
      cfg_nxt.agc_attack_point    = gain_bias_control_r[TCS_GB_AGC_HI:TCS_GB_AGC_LO];
      // Undefined code keeps the base point; the flag lets the caller notice
      if (cfg_nxt.agc_attack_point == TCS_AGC_TOP_CODE)
      begin
         cfg_nxt.agc_attack_dbm = TCS_AGC_TOP_DBM;
      end
      else if (cfg_nxt.agc_attack_point == TCS_AGC_UNDEF_CODE)
      begin
         cfg_nxt.agc_attack_dbm = TCS_AGC_BASE_DBM;
      end
      else
      begin
         cfg_nxt.agc_attack_dbm = TCS_AGC_BASE_DBM
                                + 8'(signed'({5'h00, cfg_nxt.agc_attack_point}) * TCS_AGC_STEP_DB);
      end
      cfg_nxt.agc_code_undefined  = (cfg_nxt.agc_attack_point == TCS_AGC_UNDEF_CODE);
      cfg_nxt.chip_active         = !power_down_request;
      cfg_nxt.path_active         = !power_down_request && !standby_request;
      cfg_nxt.synth_active        = !power_down_request && !standby_request;
      cfg_nxt.detector_on         = gain_bias_control_r[TCS_GB_DET_BIT] && cfg_nxt.path_active;
      cfg_nxt.reference_output_divider = crystal_divide_power_r[TCS_XP_DIV_HI:TCS_XP_DIV_LO];
      cfg_nxt.q_output_on         = !crystal_divide_power_r[TCS_XP_QUADRATURE_OUTPUT_DISABLE_BIT] && cfg_nxt.path_active;
      cfg_nxt.ref_divide          = reference_divider_r;
      cfg_nxt.loop_divide         = loop_divide;
      cfg_nxt.ref_divide_in_range = (reference_divider_r >= TCS_REF_DIV_MIN)
                                 && (reference_divider_r <= TCS_REF_DIV_MAX);
      cfg_nxt.loop_divide_in_range = (loop_divide >= TCS_LOOP_DIV_MIN)
                                  && (loop_divide <= TCS_LOOP_DIV_MAX);
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         cfg_r <= '0;
      end
      else
      begin
         cfg_r <= cfg_nxt;
      end
   end

   // Reference output keeps running through standby, stops in power-down
   tcs_refdiv #(
      .DIV_W      (5)
   ) u_refdiv (
      .mclk_i     (mclk_i),
      .rst_b_i    (rst_b_i),
      .run_i      (!power_down_request),
      .div_code_i (crystal_divide_power_r[TCS_XP_DIV_HI:TCS_XP_DIV_LO]),
      .tick_o     (reference_clock_output_o),
      .buf_on_o   (ref_buffer_on_o)
   );

   assign rd_data_o  = rd_data_r;
   assign rd_valid_o = rd_valid_r;
   assign cfg_o      = cfg_r;

endmodule : tcs_regs
`default_nettype wire

// *** sim/tcs_regs_props.sv ***
// Port-level checker of the tuner configuration and status bank
`timescale 1ns/1ps
`default_nettype none
module tcs_regs_props
   import tcs_pkg::*;
(
   input  wire logic            mclk_i,
   input  wire logic            rst_b_i,
   input  wire tcs_bus_req_type bus_req_i,
   input  wire logic [7:0]      rd_data_o,
   input  wire logic            rd_valid_o,
   input  wire logic [1:0]      pump_current_i,
   input  wire logic            autoselect_enable_i,
   input  wire logic            autoselect_done_i,
   input  wire logic            autoselect_ok_i,
   input  wire tcs_cfg_type     cfg_o,
   input  wire logic            reference_clock_output_o,
   input  wire logic            ref_buffer_on_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_b_i);
   logic up_r;
   // Decoded outputs hold zeros until the first edge after release
   always_ff @(posedge mclk_i)
   begin
      up_r <= rst_b_i;
   end
   a_read_valid_pulse: assert property (bus_req_i.rd_en |=> rd_valid_o)
      else $error("read answer missing");
   a_no_stray_valid: assert property (!bus_req_i.rd_en |=> !rd_valid_o)
      else $error("read answer without request");
   a_read_data_hold: assert property (up_r && !bus_req_i.rd_en |=> $stable(rd_data_o))
      else $error("read data moved without request");
   a_gain_step_tie: assert property (up_r |-> cfg_o.bb_gain_step_db == (cfg_o.qpsk_mode ? 4'h7 : 4'h0))
      else $error("gain step does not follow mode");
   a_agc_linear_map: assert property (up_r && cfg_o.agc_attack_point < 3'h6
      |-> cfg_o.agc_attack_dbm == $signed({5'h00, cfg_o.agc_attack_point}) * 8'sd2 - 8'sd62)
      else $error("attack point level wrong");
   a_agc_top_code: assert property (up_r && cfg_o.agc_attack_point == 3'h7
      |-> cfg_o.agc_attack_dbm == -8'sd48 && !cfg_o.agc_code_undefined)
      else $error("top attack code wrong");
   a_pd_gates_all: assert property (!cfg_o.chip_active
      |-> !cfg_o.path_active && !cfg_o.synth_active && !cfg_o.detector_on)
      else $error("block active in power-down");
   a_q_needs_path: assert property (cfg_o.q_output_on |-> cfg_o.path_active)
      else $error("q output on without path");
   a_ref_range_flag: assert property (up_r
      |-> cfg_o.ref_divide_in_range == (cfg_o.ref_divide >= 8'd22 && cfg_o.ref_divide <= 8'd182))
      else $error("reference range flag wrong");
   a_loop_range_flag: assert property (up_r
      |-> cfg_o.loop_divide_in_range == (cfg_o.loop_divide >= 13'd829 && cfg_o.loop_divide <= 13'd5374))
      else $error("loop range flag wrong");
   a_pd_buffer_off: assert property ((up_r && !cfg_o.chip_active) [*2] |-> !ref_buffer_on_o)
      else $error("reference buffer on in power-down");
   a_off_no_tick: assert property ((up_r && !ref_buffer_on_o) [*2] |-> !reference_clock_output_o)
      else $error("tick while buffer off");
   c_read: cover property (bus_req_i.rd_en ##1 rd_valid_o);
   c_power_down: cover property (up_r && !cfg_o.chip_active);
   c_undef_code: cover property (cfg_o.agc_code_undefined);
endmodule : tcs_regs_props
bind tcs_regs tcs_regs_props props_u (
   .mclk_i                   (mclk_i),
   .rst_b_i                  (rst_b_i),
   .bus_req_i                (bus_req_i),
   .rd_data_o                (rd_data_o),
   .rd_valid_o               (rd_valid_o),
   .pump_current_i           (pump_current_i),
   .autoselect_enable_i      (autoselect_enable_i),
   .autoselect_done_i        (autoselect_done_i),
   .autoselect_ok_i          (autoselect_ok_i),
   .cfg_o                    (cfg_o),
   .reference_clock_output_o (reference_clock_output_o),
   .ref_buffer_on_o          (ref_buffer_on_o)
);
`default_nettype wire

// *** sim/tcs_host_model.sv ***
// Bus master seen through the serial slave front end, one-cycle requests each followed by an idle cycle
`timescale 1ns/1ps
`default_nettype none
module tcs_host_model
   import tcs_pkg::*;
(
   input  wire logic       mclk_i,
   input  wire logic [7:0] rd_data_i,
   input  wire logic       rd_valid_i,
   output var tcs_bus_req_type bus_req_o
);
   initial bus_req_o = '0;
   // Released data fields show inverted bits so stale values never match
   task automatic drive(input tcs_bus_req_type req);
      @(negedge mclk_i);
      bus_req_o = req;
      @(negedge mclk_i);
      bus_req_o = '{ptr_addr: ~req.ptr_addr, wr_data: ~req.wr_data, default: 0};
   endtask : drive
   task automatic set_ptr(input logic [7:0] a);
      drive('{ptr_load: 1, ptr_addr: a, default: 0});
   endtask : set_ptr
   // Divider range is left to the caller, out-of-range only on purpose
   task automatic wr_at(input logic [7:0] a, input logic [7:0] d);
      drive('{ptr_load: 1, ptr_addr: a, wr_en: 1, wr_data: d, default: 0});
   endtask : wr_at
   task automatic wr_next(input logic [7:0] d);
      drive('{wr_en: 1, wr_data: d, default: 0});
   endtask : wr_next
   task automatic rd_next(output logic [7:0] d, output logic ok);
      ok = 1'b0;
      d = 8'h00;
      drive('{rd_en: 1, default: 0});
      for (int i = 0; i < 4 && !ok; i++)
      begin
         if (rd_valid_i === 1'b1)
         begin
            ok = 1'b1;
            d = rd_data_i;
         end
         else
            @(negedge mclk_i);
      end
   endtask : rd_next
   task automatic stop_rd();
      drive('{stop_read: 1, default: 0});
   endtask : stop_rd
endmodule : tcs_host_model
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench of the tuner configuration and status bank
`timescale 1ns/1ps
`default_nettype none
module tb;
   import tcs_pkg::*;
   logic            mclk_i = 1'b0;
   logic            rst_b_i = 1'b0;
   tcs_bus_req_type bus_req_i;
   logic [7:0]      rd_data_o;
   logic            rd_valid_o;
   logic [1:0]      pump_current_i = 2'b10;
   logic            autoselect_enable_i = 1'b0;
   logic            autoselect_done_i = 1'b0;
   logic            autoselect_ok_i = 1'b0;
   tcs_cfg_type     cfg_o;
   logic            reference_clock_output_o;
   logic            ref_buffer_on_o;
   int              n_errors = 0;
   int              n_tests = 0;
   int              k;
   int              n;
   logic [7:0]      d;
   logic            ok;
   always #12.5 mclk_i = ~mclk_i;
   tcs_regs dut_u (
      .mclk_i                   (mclk_i),
      .rst_b_i                  (rst_b_i),
      .bus_req_i                (bus_req_i),
      .rd_data_o                (rd_data_o),
      .rd_valid_o               (rd_valid_o),
      .pump_current_i           (pump_current_i),
      .autoselect_enable_i      (autoselect_enable_i),
      .autoselect_done_i        (autoselect_done_i),
      .autoselect_ok_i          (autoselect_ok_i),
      .cfg_o                    (cfg_o),
      .reference_clock_output_o (reference_clock_output_o),
      .ref_buffer_on_o          (ref_buffer_on_o)
   );
   tcs_host_model host_u (
      .mclk_i     (mclk_i),
      .rd_data_i  (rd_data_o),
      .rd_valid_i (rd_valid_o),
      .bus_req_o  (bus_req_i)
   );
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : stop_test
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         n_errors++;
      end
   endtask : check
   task automatic rd_chk(input logic [7:0] exp);
      host_u.rd_next(d, ok);
      if (ok !== 1'b1)
      begin
         n_errors++;
         $display("unexpected at %0t: no read answer", $time);
         stop_test();
      end
      else
         check({8'h00, d}, {8'h00, exp});
   endtask : rd_chk
   // Registered decode lags the register byte by one cycle
   task automatic settle();
      repeat (2) @(negedge mclk_i);
   endtask : settle
   task automatic ticks(input int cycles);
      n = 0;
      repeat (cycles)
      begin
         @(negedge mclk_i);
         if (reference_clock_output_o === 1'b1)
            n++;
      end
   endtask : ticks
   initial
   begin
      repeat (3) @(negedge mclk_i);
      rst_b_i = 1'b1;
      host_u.set_ptr(8'h00);
      rd_chk(8'h56);
      rd_chk(8'h08);
      rd_chk(8'h38);
      rd_chk(8'h53);
      rd_chk(8'hf8);
      rd_chk(8'h15);
      check({3'h0, cfg_o.loop_divide}, 16'd2687);
      check({8'h00, cfg_o.agc_attack_dbm}, 16'h00c8);
      ticks(10);
      check(16'(n), 16'd10);
      $display("power-on values done");
      host_u.wr_at(8'h00, 8'h0e);
      host_u.wr_next(8'hd8);
      host_u.wr_next(8'he1);
      settle();
      check({8'h00, cfg_o.agc_attack_dbm}, 16'h00d0);
      check({12'h000, cfg_o.baseband_bias_level, cfg_o.high_side_inject, cfg_o.detector_on}, 16'h0000);
      check({11'h000, cfg_o.reference_output_divider}, 16'd27);
      check({8'h00, cfg_o.ref_divide}, 16'h00e1);
      host_u.set_ptr(8'h00);
      rd_chk(8'h0e);
      rd_chk(8'hd8);
      rd_chk(8'he1);
      $display("burst write done");
      for (k = 0; k < 8; k++)
      begin
         host_u.wr_at(8'h00, {k[0], 2'b01, k[1], k[2:0], 1'b1});
         settle();
         if (k != 6)
            check({8'h00, cfg_o.agc_attack_dbm}, {8'h00, (k == 7) ? 8'hd0 : 8'(2 * k - 62)});
         check({15'h0000, cfg_o.agc_code_undefined}, {15'h0000, k == 6});
         check({12'h000, cfg_o.bb_gain_step_db}, k[0] ? 16'd7 : 16'd0);
         check({12'h000, cfg_o.baseband_bias_level, cfg_o.high_side_inject, cfg_o.detector_on},
            {12'h000, 2'b01, k[1], 1'b1});
      end
      $display("control codes done");
      host_u.wr_at(8'h01, {5'd3, 3'b000});
      settle();
      ticks(30);
      check(16'(n), 16'd10);
      host_u.wr_at(8'h01, 8'h00);
      settle();
      ticks(10);
      check({15'h0000, ref_buffer_on_o}, 16'h0000);
      check(16'(n), 16'd0);
      host_u.wr_at(8'h01, {5'd1, 3'b100});
      settle();
      ticks(10);
      check({12'h000, cfg_o.chip_active, cfg_o.path_active, cfg_o.synth_active, ref_buffer_on_o}, 16'h0000);
      check(16'(n), 16'd0);
      host_u.set_ptr(8'h00);
      rd_chk(8'hbf);
      host_u.wr_at(8'h01, {5'd1, 3'b010});
      settle();
      ticks(10);
      check({12'h000, cfg_o.chip_active, cfg_o.path_active, cfg_o.synth_active, ref_buffer_on_o}, 16'h0009);
      check(16'(n), 16'd10);
      host_u.wr_at(8'h01, {5'd1, 3'b001});
      settle();
      check({14'h0000, cfg_o.path_active, cfg_o.q_output_on}, 16'h0002);
      host_u.wr_at(8'h01, 8'h08);
      $display("power modes done");
      host_u.wr_at(8'h03, 8'h0c);
      host_u.wr_next(8'hff);
      host_u.wr_at(8'h05, 8'h00);
      settle();
      check({3'h0, cfg_o.loop_divide}, 16'd415);
      host_u.set_ptr(8'h03);
      rd_chk(8'h0c);
      rd_chk(8'hf8);
      rd_chk(8'h15);
      host_u.set_ptr(8'h09);
      rd_chk(8'h00);
      $display("refused accesses done");
      pump_current_i = 2'b01;
      host_u.stop_rd();
      host_u.set_ptr(8'h05);
      rd_chk(8'h09);
      autoselect_enable_i = 1'b1;
      host_u.wr_at(8'h04, 8'hf8);
      host_u.set_ptr(8'h05);
      rd_chk(8'h08);
      @(negedge mclk_i);
      autoselect_done_i = 1'b1;
      autoselect_ok_i = 1'b1;
      @(negedge mclk_i);
      autoselect_done_i = 1'b0;
      host_u.set_ptr(8'h05);
      rd_chk(8'h0b);
      autoselect_enable_i = 1'b0;
      settle();
      host_u.set_ptr(8'h05);
      rd_chk(8'h09);
      $display("status flags done");
      stop_test();
   end
endmodule : tb
`default_nettype wire
